/* verilog/wwdt_top.sv */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module wwdt_top
(
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             WDOG_NMI_REQUEST_O,
	output logic             WDOG_SYSTEM_RESET_O,
	output logic             IRQ_O
);

////////////////////////////////////////////////////////////////////////////////
	// windowed watchdog: a 16-bit up-counter fed by a 2 or 128 clock prescaler.
	// a service write outside the forbidden window reloads it; an overflow or
	// a service inside the window starts prewarning, which ends in a held reset.
	// software reaches everything through a one-wait-state apb slave.
	// the nmi is not gated by the mask; only the status interrupt is.
	logic                           acc;
	logic                           wr;
	logic                           rd;
	logic                           hit;
	logic [31:0]                    rdata;
	wwdt_pkg::wwdt_ctrl_s           ctrl_q,   ctrl_d;
	logic [7:0]                     reload_q, reload_d;
	logic [7:0]                     window_q, window_d;
	logic [15:0]                    cnt_q,    cnt_d;
	logic [6:0]                     pre_q,    pre_d;
	logic [7:0]                     pw_q,     pw_d;
	wwdt_pkg::wwdt_state_e          st_q,     st_d;
	logic [wwdt_pkg::WWDT_ST_NBITS-1:0] stat_q, stat_d;
	logic [wwdt_pkg::WWDT_ST_NBITS-1:0] mask_q, mask_d;
	logic [wwdt_pkg::WWDT_ST_NBITS-1:0] ev;
	logic                           nmi_q,    nmi_d;
	logic                           srst_q,   srst_d;
	logic                           irq_q,    irq_d;
	logic [31:0]                    prdata_q, prdata_d;
	logic                           pready_q, pready_d;
	logic                           perr_q,   perr_d;
	logic                           tick;
	logic                           serve;
	logic                           in_win;

////////////////////////////////////////////////////////////////////////////////
	// apb decode; one wait state, answer registered
	// the !pready_q term keeps a held access phase from being taken twice,
	// which would otherwise repeat a status clear or a service write
	assign acc   = PSEL_I && PENABLE_I && !pready_q;
	assign wr    = acc && PWRITE_I;
	assign rd    = acc && !PWRITE_I;
	assign serve = wr && (PADDR_I == wwdt_pkg::WWDT_SERV_OFS)
		&& (PWDATA_I == wwdt_pkg::WWDT_SERV_KEY);

	// read mux, unmapped addresses flagged as errors
	always_comb
	begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		unique case (PADDR_I)
			wwdt_pkg::WWDT_CTRL_OFS:   rdata = {29'h0, ctrl_q};
			wwdt_pkg::WWDT_RELOAD_OFS: rdata = {24'h0, reload_q};
			wwdt_pkg::WWDT_WINDOW_OFS: rdata = {24'h0, window_q};
			wwdt_pkg::WWDT_COUNT_OFS:  rdata = {16'h0, cnt_q};
			wwdt_pkg::WWDT_STAT_OFS:   rdata = {29'h0, stat_q};
			wwdt_pkg::WWDT_MASK_OFS:   rdata = {29'h0, mask_q};
			wwdt_pkg::WWDT_SERV_OFS:   rdata = 32'h0000_0000;
			default:                   hit   = 1'b0;
		endcase
	end

	// bus answer registers
	always_comb
	begin
		pready_d = acc;
		perr_d   = acc && !hit;
		prdata_d = rd ? rdata : 32'h0000_0000;
	end

////////////////////////////////////////////////////////////////////////////////
	// configuration registers; reload and window may be rewritten at any time.
	// reload only matters at the next service write, the window applies at once
	// hazard: a window byte below the reload byte makes the window useless
	// enable is sticky: once running only RST_N_I stops the watchdog
	always_comb
	begin
		ctrl_d   = ctrl_q;
		reload_d = reload_q;
		window_d = window_q;
		mask_d   = mask_q;
		if (wr)
		begin
			unique case (PADDR_I)
				wwdt_pkg::WWDT_CTRL_OFS:
				begin
					ctrl_d.div_sel = PWDATA_I[wwdt_pkg::WWDT_CTRL_DIV_BIT];
					ctrl_d.win_en  = PWDATA_I[wwdt_pkg::WWDT_CTRL_WIN_BIT];
					// once started the watchdog cannot be stopped by software
					ctrl_d.enable  = ctrl_q.enable | PWDATA_I[wwdt_pkg::WWDT_CTRL_EN_BIT];
				end
				wwdt_pkg::WWDT_RELOAD_OFS: reload_d = PWDATA_I[7:0];
				wwdt_pkg::WWDT_WINDOW_OFS: window_d = PWDATA_I[7:0];
				wwdt_pkg::WWDT_MASK_OFS:   mask_d   = PWDATA_I[wwdt_pkg::WWDT_ST_NBITS-1:0];
				default: ;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// prescaler: tick every 2 or 128 clocks
	// held at zero while disabled, so the first tick after enable comes a full
	// divide later; a divider change mid-count takes effect at once
	always_comb
	begin
		tick  = 1'b0;
		pre_d = pre_q + 7'h01;
		if (!ctrl_q.enable)
			pre_d = 7'h00;
		else if (pre_q >= (ctrl_q.div_sel ? wwdt_pkg::WWDT_DIV_SLOW
			: wwdt_pkg::WWDT_DIV_FAST))
		begin
			pre_d = 7'h00;
			tick  = 1'b1;
		end
	end

	// forbidden window: count from zero up to {window,00}
	// inclusive: a count equal to {window,00} is still refused
	assign in_win = ctrl_q.win_en && (cnt_q <= {window_q, 8'h00});

////////////////////////////////////////////////////////////////////////////////
	// watchdog state machine and counter
	// the counter keeps running through prewarning so software can watch it;
	// prewarning is counted in ticks, so its length follows the divider
	// the reset state is left only through RST_N_I
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		pw_d   = pw_q;
		nmi_d  = nmi_q;
		srst_d = srst_q;
		ev     = '0;
		unique case (st_q)
			wwdt_pkg::WWDT_RUN:
			begin
				if (ctrl_q.enable && serve && in_win)
				begin
					st_d = wwdt_pkg::WWDT_PRE;
					pw_d = 8'h00;
					ev[wwdt_pkg::WWDT_ST_INV_BIT] = 1'b1;
					ev[wwdt_pkg::WWDT_ST_PRE_BIT] = 1'b1;
				end
				else if (serve)
					cnt_d = {reload_q, 8'h00};
				else if (tick)
				begin
					cnt_d = cnt_q + 16'h0001;
					if (cnt_q == 16'hffff)
					begin
						st_d  = wwdt_pkg::WWDT_PRE;
						pw_d  = 8'h00;
						nmi_d = 1'b1;
						ev[wwdt_pkg::WWDT_ST_OVF_BIT] = 1'b1;
						ev[wwdt_pkg::WWDT_ST_PRE_BIT] = 1'b1;
					end
				end
			end
			wwdt_pkg::WWDT_PRE:
			begin
				// service writes are ignored here
				if (tick)
				begin
					cnt_d = cnt_q + 16'h0001;
					pw_d  = pw_q + 8'h01;
					if (pw_q == wwdt_pkg::WWDT_PREWARN_CNT - 8'h01)
					begin
						st_d   = wwdt_pkg::WWDT_RST;
						srst_d = 1'b1;
					end
				end
			end
			wwdt_pkg::WWDT_RST:
				srst_d = 1'b1;   // held until the system reset clears the block
			default:
				st_d = wwdt_pkg::WWDT_RUN;
		endcase
	end

	// sticky status: set wins over the read clear
	// irq is built from the next status and mask so it moves with the flops,
	// a read that clears the last bit drops the interrupt on the same edge
	always_comb
	begin
		stat_d = stat_q;
		if (rd && (PADDR_I == wwdt_pkg::WWDT_STAT_OFS))
			stat_d = '0;
		stat_d = stat_d | ev;
		irq_d  = |(stat_d & mask_d);
	end

////////////////////////////////////////////////////////////////////////////////
	// one register process per state group, all on CLK_I
	// bus answer; pslverr rides with pready, an unmapped access changes nothing
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			perr_q   <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			perr_q   <= perr_d;
		end
	end

	// configuration registers
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			ctrl_q   <= '0;
			reload_q <= wwdt_pkg::WWDT_RELOAD_RST;
			window_q <= wwdt_pkg::WWDT_WINDOW_RST;
			mask_q   <= '0;
		end
		else
		begin
			ctrl_q   <= ctrl_d;
			reload_q <= reload_d;
			window_q <= window_d;
			mask_q   <= mask_d;
		end
	end

	// prescaler
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			pre_q <= 7'h00;
		end
		else
		begin
			pre_q <= pre_d;
		end
	end

	// state machine, counter, nmi and system reset
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			cnt_q  <= wwdt_pkg::WWDT_COUNT_RST;
			pw_q   <= 8'h00;
			st_q   <= wwdt_pkg::WWDT_RUN;
			nmi_q  <= 1'b0;
			srst_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			pw_q   <= pw_d;
			st_q   <= st_d;
			nmi_q  <= nmi_d;
			srst_q <= srst_d;
		end
	end

	// status and interrupt
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			stat_q <= '0;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			irq_q  <= irq_d;
		end
	end

	// outputs straight from flops
	// nmi and system reset stay high until RST_N_I; the system reset that they
	// cause is expected to pull RST_N_I low and so clear them
	assign PRDATA_O            = prdata_q;
	assign PREADY_O            = pready_q;
	assign PSLVERR_O           = perr_q;
	assign WDOG_NMI_REQUEST_O  = nmi_q;
	assign WDOG_SYSTEM_RESET_O = srst_q;
	assign IRQ_O               = irq_q;

endmodule // wwdt_top

/* shared/wwdt_pkg.sv */
// Summary of operation
// - missed refresh before overflow raises nmi request and starts prewarning.
// - prewarning lasts 0x30 counter counts, then system reset output asserts.
// - refresh inside active window is invalid: prewarning without nmi, then reset.
// - forbidden window spans counter zero up to window byte followed by 0x00.
// - valid refresh loads counter with reload byte times 256, counts upward.
// - counter input is peripheral clock divided by 2 or by 128.
// - reload byte sets only counter high byte; low byte restarts at zero.
// - refresh-to-overflow period is 2^(1+6*sel)*(65536-reload*256) clocks.
// - with window on and window byte above reload, window byte sets earliest valid refresh.
package wwdt_pkg;

	// register byte addresses
	localparam logic [11:0] WWDT_CTRL_OFS   = 12'h000;
	localparam logic [11:0] WWDT_RELOAD_OFS = 12'h004;
	localparam logic [11:0] WWDT_WINDOW_OFS = 12'h008;
	localparam logic [11:0] WWDT_COUNT_OFS  = 12'h00c;
	localparam logic [11:0] WWDT_STAT_OFS   = 12'h010;
	localparam logic [11:0] WWDT_MASK_OFS   = 12'h014;
	localparam logic [11:0] WWDT_SERV_OFS   = 12'h018;

	// control field positions
	localparam int WWDT_CTRL_EN_BIT  = 0;
	localparam int WWDT_CTRL_DIV_BIT = 1;
	localparam int WWDT_CTRL_WIN_BIT = 2;

	// status field positions
	localparam int WWDT_ST_OVF_BIT  = 0;
	localparam int WWDT_ST_INV_BIT  = 1;
	localparam int WWDT_ST_PRE_BIT  = 2;
	localparam int WWDT_ST_NBITS    = 3;

	// reset values
	localparam logic [7:0]  WWDT_RELOAD_RST = 8'h00;
	localparam logic [7:0]  WWDT_WINDOW_RST = 8'h00;
	localparam logic [15:0] WWDT_COUNT_RST  = 16'h0000;

	// prescaler divisors, prewarning length in counter ticks
	localparam logic [6:0] WWDT_DIV_SLOW   = 7'h7f;   // 128 - 1
	localparam logic [6:0] WWDT_DIV_FAST   = 7'h01;   // 2 - 1
	localparam logic [7:0] WWDT_PREWARN_CNT = 8'h30;

	// software service key; written to the service register
	localparam logic [31:0] WWDT_SERV_KEY = 32'h0000_00a5;

	typedef enum logic [2:0]
	{
		WWDT_RUN  = 3'b001,
		WWDT_PRE  = 3'b010,
		WWDT_RST  = 3'b100
	} wwdt_state_e;

	typedef struct packed
	{
		logic enable;
		logic div_sel;
		logic win_en;
	} wwdt_ctrl_s;

endpackage

/* test/wwdt_sva.sv */
`timescale 1ns/1ps
module wwdt_sva
(
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic [31:0] PRDATA_O,
	input wire logic        WDOG_NMI_REQUEST_O,
	input wire logic        WDOG_SYSTEM_RESET_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// clocks since the nmi rose, saturating; prewarning must last this long
	logic [7:0] nmi_age;
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I || !WDOG_NMI_REQUEST_O)
			nmi_age <= 8'h00;
		else if (nmi_age != 8'hff)
			nmi_age <= nmi_age + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	// access phase still waiting, then prewarning quiet time
	sequence s_wait;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence
	sequence s_quiet;
		(!WDOG_SYSTEM_RESET_O)[*8];
	endsequence
	property p_ready_lat;
		s_wait |=> PREADY_O;
	endproperty
	property p_ready_pulse;
		PREADY_O |=> !PREADY_O;
	endproperty
	property p_idle;
		!PSEL_I |=> !PREADY_O;
	endproperty
	property p_err;
		PSLVERR_O |-> PREADY_O;
	endproperty
	property p_rdata;
		!PREADY_O |-> PRDATA_O == 32'h0000_0000;
	endproperty
	property p_nmi_hold;
		WDOG_NMI_REQUEST_O |=> WDOG_NMI_REQUEST_O;
	endproperty
	property p_rst_hold;
		WDOG_SYSTEM_RESET_O |=> WDOG_SYSTEM_RESET_O;
	endproperty
	property p_pre_gap;
		$rose(WDOG_NMI_REQUEST_O) |-> s_quiet;
	endproperty
	property p_pre_len;
		$rose(WDOG_SYSTEM_RESET_O) && WDOG_NMI_REQUEST_O |-> nmi_age >= 8'h5e;
	endproperty
	a_ready_lat: assert property (p_ready_lat) else $error("no ready");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready long");
	a_idle: assert property (p_idle) else $error("ready idle");
	a_err: assert property (p_err) else $error("err alone");
	a_rdata: assert property (p_rdata) else $error("rdata idle");
	a_nmi_hold: assert property (p_nmi_hold) else $error("nmi drop");
	a_rst_hold: assert property (p_rst_hold) else $error("reset drop");
	a_pre_gap: assert property (p_pre_gap) else $error("reset early");
	a_pre_len: assert property (p_pre_len) else $error("prewarning short");
endmodule // wwdt_sva
bind wwdt_top wwdt_sva wwdt_sva_inst (.CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PREADY_O,
	.PSLVERR_O, .PRDATA_O, .WDOG_NMI_REQUEST_O, .WDOG_SYSTEM_RESET_O);

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
	logic        CLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, er;
	logic [11:0] PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O, rd;
	logic        PREADY_O, PSLVERR_O, WDOG_NMI_REQUEST_O, WDOG_SYSTEM_RESET_O, IRQ_O;
	int          bad_count, cmp_count, n;
	wwdt_top wwdt_top_inst (.CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
		.PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .WDOG_NMI_REQUEST_O,
		.WDOG_SYSTEM_RESET_O, .IRQ_O);
	// 50 ns clock
	initial
	begin
		CLK_I = 1'b0;
		forever #25 CLK_I = ~CLK_I;
	end
	////////////////////////////////////////////////////////////////
	task finish_test;
		$display("bad %0d cmp %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task to_out;
		bad_count++;
		finish_test();
	endtask
	// apb transfer; request held until ready is sampled
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		n = 0;
		@(posedge CLK_I);
		while (PREADY_O !== 1'b1)
		begin
			n++;
			if (n > 9)
				to_out();
			@(posedge CLK_I);
		end
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// cycles until nmi (r=0) or system reset (r=1)
	task wt(input bit r, input int lim);
		n = 0;
		while ((r ? WDOG_SYSTEM_RESET_O : WDOG_NMI_REQUEST_O) !== 1'b1)
		begin
			@(posedge CLK_I);
			n++;
			if (n > lim)
				to_out();
		end
	endtask
	task rst;
		RST_N_I <= 1'b0;
		repeat (5) @(posedge CLK_I);
		RST_N_I <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	// sequence of scenarios; only the slow divider run is long
	initial
	begin
		{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, RST_N_I} = '0;
		bad_count = 0;
		cmp_count = 0;
		rst();
		rdc(wwdt_pkg::WWDT_CTRL_OFS, 32'h0);
		rdc(wwdt_pkg::WWDT_COUNT_OFS, 32'h0);
		rdc(12'h01c, 32'h0);
		chk(er, 1'b1);
		bus(1'b1, wwdt_pkg::WWDT_RELOAD_OFS, 32'hff);
		bus(1'b1, wwdt_pkg::WWDT_MASK_OFS, 32'h7);
		bus(1'b1, wwdt_pkg::WWDT_CTRL_OFS, 32'h1);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		bus(1'b0, wwdt_pkg::WWDT_COUNT_OFS, 32'h0);
		chk(rd[15:8], 8'hff);
		wt(1'b0, 600);
		chk(n inside {[504:512]}, 1'b1);
		chk(IRQ_O, 1'b1);
		wt(1'b1, 200);
		chk(n inside {[94:98]}, 1'b1);
		rdc(wwdt_pkg::WWDT_STAT_OFS, 32'h5);
		rdc(wwdt_pkg::WWDT_STAT_OFS, 32'h0);
		chk(IRQ_O, 1'b0);
		// slow divider, interrupt masked off
		rst();
		bus(1'b1, wwdt_pkg::WWDT_RELOAD_OFS, 32'hff);
		bus(1'b1, wwdt_pkg::WWDT_CTRL_OFS, 32'h3);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		wt(1'b0, 33000);
		chk(n inside {[32700:32768]}, 1'b1);
		chk(IRQ_O, 1'b0);
		// refresh inside window, then again during prewarning
		rst();
		bus(1'b1, wwdt_pkg::WWDT_WINDOW_OFS, 32'hff);
		bus(1'b1, wwdt_pkg::WWDT_MASK_OFS, 32'h7);
		bus(1'b1, wwdt_pkg::WWDT_CTRL_OFS, 32'h5);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		wt(1'b1, 120);
		chk(n inside {[90:94]}, 1'b1);
		chk(WDOG_NMI_REQUEST_O, 1'b0);
		rdc(wwdt_pkg::WWDT_STAT_OFS, 32'h6);
		// window byte above reload: only counts past {window,00} may be served
		rst();
		bus(1'b1, wwdt_pkg::WWDT_RELOAD_OFS, 32'hff);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		bus(1'b1, wwdt_pkg::WWDT_RELOAD_OFS, 32'hfd);
		bus(1'b1, wwdt_pkg::WWDT_WINDOW_OFS, 32'hfe);
		bus(1'b1, wwdt_pkg::WWDT_CTRL_OFS, 32'h5);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		bus(1'b0, wwdt_pkg::WWDT_COUNT_OFS, 32'h0);
		chk(rd[15:8], 8'hfd);
		repeat (600) @(posedge CLK_I);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		rdc(wwdt_pkg::WWDT_STAT_OFS, 32'h0);
		repeat (400) @(posedge CLK_I);
		bus(1'b1, wwdt_pkg::WWDT_SERV_OFS, wwdt_pkg::WWDT_SERV_KEY);
		rdc(wwdt_pkg::WWDT_STAT_OFS, 32'h6);
		chk(WDOG_NMI_REQUEST_O, 1'b0);
		finish_test();
	end
endmodule // tb
